// [common/acgc_defs.vh]
// Constants for the converter control block
`ifndef ACGC_DEFS_VH
`define ACGC_DEFS_VH
// Serial command opcode for a register write
`define ACGC_OP_WRITE 8'h08
// Register offsets for the channel configuration registers
`define ACGC_ADDR_PIN_FUNCTION 8'h01
`define ACGC_ADDR_DIRECTION 8'h02
`define ACGC_ADDR_OUTPUT_DRIVE 8'h03
`define ACGC_ADDR_OUTPUT_LEVEL 8'h04
// Reset values: every channel is an analog input
`define ACGC_RST_PIN_FUNCTION 8'h00
`define ACGC_RST_DIRECTION 8'h00
`define ACGC_RST_OUTPUT_DRIVE 8'h00
`define ACGC_RST_OUTPUT_LEVEL 8'h00
// Output append selection that adds the status flags
`define ACGC_OUTPUT_APPEND_SELECT 2'b10
// Status flag positions in the appended nibble
`define ACGC_STAT_CRC_ERR 3
`define ACGC_STAT_CAL_BUSY 2
`define ACGC_STAT_ALERT_HIGH 1
`define ACGC_STAT_ALERT_LOW 0
// Checksum polynomial x^8 + x^2 + x + 1, low terms
`define ACGC_CRC_POLY 8'h07
`define ACGC_CRC_INIT 8'h00
`endif

// [rtl/acgc_crc8.v]
// Per-byte checksum over one byte
`timescale 1ns/100ps
`include "acgc_defs.vh"
module acgc_crc8
(
  // Byte in, checksum out
  input wire [7:0] data_i,
  output reg [7:0] crc_o
);
  integer i;
  reg [7:0] c;
  always @*
  begin
    c = `ACGC_CRC_INIT;
    for (i = 7; i >= 0; i = i - 1)
    begin
      if (c[7] ^ data_i[i])
        c = {c[6:0], 1'b0} ^ `ACGC_CRC_POLY;
      else
        c = {c[6:0], 1'b0};
    end
    crc_o = c;
  end
endmodule

// [rtl/acgc_average.v]
// Averaging accumulator for conversion codes
`timescale 1ns/100ps
module acgc_average
(
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Sample stream
  input wire clear_i,
  input wire sample_i,
  input wire [11:0] code_i,
  input wire [2:0] averaging_ratio_i,
  // Averaged result
  output wire last_o,
  output reg done_o,
  output reg [15:0] result_o
);
  reg [18:0] sum;
  reg [7:0] count;
  wire [7:0] total;
  wire [18:0] new_sum;
  wire [22:0] scaled;
  assign total = (averaging_ratio_i == 3'h0) ? 8'h01 : (8'h01 << averaging_ratio_i);
  assign last_o = (count + 8'h01) == total;
  assign new_sum = sum + {7'h00, code_i};
  // Mean scaled so one step is a sixteenth of a converter code
  assign scaled = {new_sum, 4'h0} >> averaging_ratio_i;
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sum <= 19'h00000;
      count <= 8'h00;
      done_o <= 1'b0;
      result_o <= 16'h0000;
    end
    else
    begin
      done_o <= 1'b0;
      if (clear_i)
      begin
        sum <= 19'h00000;
        count <= 8'h00;
      end
      else if (sample_i)
      begin
        if (last_o)
        begin
          sum <= 19'h00000;
          count <= 8'h00;
          result_o <= scaled[15:0];
          done_o <= 1'b1;
        end
        else
        begin
          sum <= new_sum;
          count <= count + 8'h01;
        end
      end
    end
  end
endmodule

// [rtl/acgc_top.v]
// Converter control: channels, averaging, calibration and checksummed serial port
`timescale 1ns/100ps
`include "acgc_defs.vh"
module acgc_top
(
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Serial link pins
  input wire cs_b_i,
  input wire sclk_i,
  input wire sdi_i,
  output reg sdo_o,
  output reg sdo_oe_o,
  // Configuration bits
  input wire crc_enable_i,
  input wire [2:0] averaging_ratio_i,
  input wire auto_mode_i,
  input wire [7:0] sequence_channel_mask_i,
  input wire checksum_error_interrupt_enable_i,
  input wire [1:0] output_append_select_i,
  input wire stop_on_error_i,
  input wire [11:0] high_threshold_i,
  input wire [11:0] low_threshold_i,
  // Calibration trigger and error clear, one-cycle writes of 1b
  input wire cal_trigger_i,
  input wire error_clear_i,
  // Manual conversion request
  input wire conv_request_i,
  input wire [2:0] conv_channel_i,
  // Converter core
  output reg adc_start_o,
  output reg [2:0] adc_channel_o,
  input wire adc_done_i,
  input wire [11:0] adc_code_i,
  output reg adc_cal_o,
  input wire adc_cal_done_i,
  // Status
  output reg cal_busy_o,
  output reg received_checksum_error_flag_o,
  output wire checksum_alert_o,
  output reg alert_high_o,
  output reg alert_low_o,
  output reg [15:0] result_o,
  output reg [2:0] result_channel_o,
  output reg result_valid_o,
  output reg [7:0] input_level_register_o,
  // Channel pins
  input wire [7:0] pin_i,
  output wire [7:0] pin_o,
  output wire [7:0] pin_oe_o
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_CONV = 4'b0010;
  localparam [3:0] ST_WAIT = 4'b0100;
  localparam [3:0] ST_CAL = 4'b1000;

  reg [1:0] cs_s;
  reg [1:0] sclk_s;
  reg [1:0] sdi_s;
  reg [7:0] pin_m;
  reg [7:0] pin_s;
  reg sclk_d;
  reg cs_d;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_fall;
  wire active;

  reg [7:0] pin_function;
  reg [7:0] direction;
  reg [7:0] output_drive_select;
  reg [7:0] output_level_register;

  reg [3:0] state;
  reg halted;
  reg [2:0] next_chan;
  reg next_found;
  integer k;
  reg [2:0] cand;
  wire avg_last;
  wire avg_done;
  wire [15:0] avg_result;
  wire avg_on;
  wire crc_error;

  reg [2:0] bit_cnt;
  reg [2:0] slot_cnt;
  reg [7:0] rx_sh;
  reg [7:0] rx_pend;
  reg [1:0] rx_idx;
  reg [7:0] rx_op;
  reg [7:0] rx_addr;
  reg frame_bad;
  reg [7:0] tx_sh;
  reg [23:0] tx_word;
  wire [7:0] rx_byte;
  wire [7:0] rx_crc;
  wire [7:0] tx_data;
  wire [7:0] tx_crc;
  reg [7:0] tx_load;
  wire [3:0] status;
  wire [23:0] out_word;

  assign sclk_rise = sclk_s[1] & ~sclk_d;
  assign sclk_fall = ~sclk_s[1] & sclk_d;
  assign cs_fall = ~cs_s[1] & cs_d;
  assign active = ~cs_s[1];
  assign avg_on = averaging_ratio_i != 3'h0;
  assign rx_byte = {rx_sh[6:0], sdi_s[1]};

  // Pin inputs through two flops
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      cs_s <= 2'b11;
      sclk_s <= 2'b00;
      sdi_s <= 2'b00;
      pin_m <= 8'h00;
      pin_s <= 8'h00;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end
    else
    begin
      cs_s <= {cs_s[0], cs_b_i};
      sclk_s <= {sclk_s[0], sclk_i};
      sdi_s <= {sdi_s[0], sdi_i};
      pin_m <= pin_i;
      pin_s <= pin_m;
      sclk_d <= sclk_s[1];
      cs_d <= cs_s[1];
    end
  end

  // Per-channel pin decode
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : gen_pin
      assign pin_oe_o[g] = pin_function[g] & direction[g] &
                           (output_drive_select[g] | ~output_level_register[g]);
      assign pin_o[g] = output_drive_select[g] & output_level_register[g];
    end
  endgenerate

  always @(posedge clk_i)
  begin
    if (!rst_b_i)
      input_level_register_o <= 8'h00;
    else
      input_level_register_o <= pin_s & pin_function;
  end

  // Next enabled analog channel after the current one
  always @*
  begin
    next_chan = adc_channel_o;
    next_found = 1'b0;
    cand = adc_channel_o;
    for (k = 7; k >= 1; k = k - 1)
    begin
      // Channel index wraps in three bits
      cand = adc_channel_o + k[2:0];
      if (sequence_channel_mask_i[cand] & ~pin_function[cand])
      begin
        next_chan = cand;
        next_found = 1'b1;
      end
    end
    if (!next_found)
      next_chan = adc_channel_o;
  end

  acgc_average u_average
  (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .clear_i(state == ST_IDLE),
    .sample_i((state == ST_WAIT) & adc_done_i),
    .code_i(adc_code_i),
    .averaging_ratio_i(averaging_ratio_i),
    .last_o(avg_last),
    .done_o(avg_done),
    .result_o(avg_result)
  );

  // Conversion sequencing and calibration
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state <= ST_IDLE;
      adc_start_o <= 1'b0;
      adc_channel_o <= 3'h0;
      adc_cal_o <= 1'b0;
      cal_busy_o <= 1'b0;
      halted <= 1'b0;
    end
    else
    begin
      adc_start_o <= 1'b0;
      if (cal_trigger_i)
        cal_busy_o <= 1'b1;
      if (!auto_mode_i)
        halted <= 1'b0;
      else if (stop_on_error_i & crc_error)
        halted <= 1'b1;
      case (state)
        ST_IDLE:
        begin
          if (cal_busy_o)
          begin
            adc_cal_o <= 1'b1;
            state <= ST_CAL;
          end
          else if (!auto_mode_i & conv_request_i)
          begin
            adc_channel_o <= conv_channel_i;
            state <= ST_CONV;
          end
          else if (auto_mode_i & ~halted & (sequence_channel_mask_i & ~pin_function) != 8'h00)
          begin
            adc_channel_o <= next_chan;
            state <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          adc_start_o <= 1'b1;
          state <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (adc_done_i)
          begin
            if (avg_last)
              state <= ST_IDLE;
            else
              state <= ST_CONV;
          end
        end
        ST_CAL:
        begin
          if (adc_cal_done_i)
          begin
            // clear when finished, unless a trigger coincides
            adc_cal_o <= 1'b0;
            cal_busy_o <= cal_trigger_i;
            state <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Result capture and threshold compare
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      result_o <= 16'h0000;
      result_channel_o <= 3'h0;
      result_valid_o <= 1'b0;
      alert_high_o <= 1'b0;
      alert_low_o <= 1'b0;
    end
    else
    begin
      result_valid_o <= avg_done;
      if (avg_done)
      begin
        result_o <= avg_result;
        result_channel_o <= adc_channel_o;
        alert_high_o <= avg_result[15:4] > high_threshold_i;
        alert_low_o <= avg_result[15:4] < low_threshold_i;
      end
    end
  end

  assign status = {received_checksum_error_flag_o, cal_busy_o, alert_high_o, alert_low_o};
  assign out_word = avg_on ?
    {result_o, (output_append_select_i == `ACGC_OUTPUT_APPEND_SELECT) ? status : 4'h0, 4'h0} :
    {result_o[15:4], (output_append_select_i == `ACGC_OUTPUT_APPEND_SELECT) ? status : 4'h0, 8'h00};

  acgc_crc8 u_rx_crc
  (
    .data_i(rx_pend),
    .crc_o(rx_crc)
  );
  assign tx_data = (slot_cnt[2:1] == 2'h0) ? tx_word[23:16] :
                   (slot_cnt[2:1] == 2'h1) ? tx_word[15:8] :
                   (slot_cnt[2:1] == 2'h2) ? tx_word[7:0] : 8'h00;
  acgc_crc8 u_tx_crc
  (
    .data_i(tx_data),
    .crc_o(tx_crc)
  );

  // Byte that follows on the line at each byte boundary
  always @*
  begin
    if (crc_enable_i)
      tx_load = slot_cnt[0] ? tx_crc : tx_data;
    else
      tx_load = (slot_cnt == 3'h0) ? tx_word[23:16] :
                (slot_cnt == 3'h1) ? tx_word[15:8] :
                (slot_cnt == 3'h2) ? tx_word[7:0] : 8'h00;
  end

  assign crc_error = active & sclk_rise & (bit_cnt == 3'h7) & crc_enable_i &
                     slot_cnt[0] & (rx_byte != rx_crc);
  assign checksum_alert_o = checksum_error_interrupt_enable_i & received_checksum_error_flag_o;

  // Serial frame receive, transmit and register writes
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      bit_cnt <= 3'h0;
      slot_cnt <= 3'h0;
      rx_sh <= 8'h00;
      rx_pend <= 8'h00;
      rx_idx <= 2'h0;
      rx_op <= 8'h00;
      rx_addr <= 8'h00;
      frame_bad <= 1'b0;
      tx_sh <= 8'h00;
      tx_word <= 24'h000000;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
      received_checksum_error_flag_o <= 1'b0;
      pin_function <= `ACGC_RST_PIN_FUNCTION;
      direction <= `ACGC_RST_DIRECTION;
      output_drive_select <= `ACGC_RST_OUTPUT_DRIVE;
      output_level_register <= `ACGC_RST_OUTPUT_LEVEL;
    end
    else
    begin
      sdo_oe_o <= active;
      // set wins, write of 1b clears
      received_checksum_error_flag_o <= crc_error |
        (received_checksum_error_flag_o & ~error_clear_i);
      if (!active)
      begin
        bit_cnt <= 3'h0;
        slot_cnt <= 3'h0;
        rx_idx <= 2'h0;
        frame_bad <= 1'b0;
      end
      if (cs_fall)
      begin
        tx_word <= out_word;
        tx_sh <= out_word[23:16];
        sdo_o <= out_word[23];
      end
      else if (active & sclk_fall)
      begin
        if (bit_cnt == 3'h0)
        begin
          tx_sh <= tx_load;
          sdo_o <= tx_load[7];
        end
        else
        begin
          tx_sh <= {tx_sh[6:0], 1'b0};
          sdo_o <= tx_sh[6];
        end
      end
      if (active & sclk_rise)
      begin
        rx_sh <= rx_byte;
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7)
        begin
          slot_cnt <= slot_cnt + 3'h1;
          if (crc_enable_i & ~slot_cnt[0])
            rx_pend <= rx_byte;
          else if (crc_error)
            frame_bad <= 1'b1;
          else if (!frame_bad)
          begin
            rx_idx <= rx_idx + 2'h1;
            if (rx_idx == 2'h0)
              rx_op <= crc_enable_i ? rx_pend : rx_byte;
            else if (rx_idx == 2'h1)
              rx_addr <= crc_enable_i ? rx_pend : rx_byte;
            else if (rx_idx == 2'h2 && rx_op == `ACGC_OP_WRITE &&
                     !received_checksum_error_flag_o)
            begin
              case (rx_addr)
                `ACGC_ADDR_PIN_FUNCTION: pin_function <= crc_enable_i ? rx_pend : rx_byte;
                `ACGC_ADDR_DIRECTION: direction <= crc_enable_i ? rx_pend : rx_byte;
                `ACGC_ADDR_OUTPUT_DRIVE: output_drive_select <= crc_enable_i ? rx_pend : rx_byte;
                `ACGC_ADDR_OUTPUT_LEVEL: output_level_register <= crc_enable_i ? rx_pend : rx_byte;
                default: pin_function <= pin_function;
              endcase
            end
          end
        end
      end
    end
  end
endmodule

// [sim/acgc_top_properties.sv]
// Port checker for the converter control top
`timescale 1ns/100ps
module acgc_top_properties
(
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Watched ports
  input wire cs_b_i, input wire sdo_oe_o,
  input wire cal_trigger_i, input wire adc_cal_done_i,
  input wire adc_cal_o, input wire cal_busy_o,
  input wire error_clear_i, input wire received_checksum_error_flag_o,
  input wire checksum_alert_o, input wire checksum_error_interrupt_enable_i,
  input wire adc_done_i, input wire result_valid_o,
  input wire [15:0] result_o, input wire alert_high_o,
  input wire [11:0] high_threshold_i, input wire [7:0] pin_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_RST_PINS:
    assert property ($rose(rst_b_i) |-> pin_oe_o == 8'h00)
    else $error("pins driven after reset");
  AST_CAL_START:
    assert property (cal_trigger_i |=> cal_busy_o)
    else $error("calibration bit not set");
  AST_CAL_END:
    assert property (adc_cal_done_i && !cal_trigger_i |=> !cal_busy_o && !adc_cal_o)
    else $error("calibration bit not cleared");
  AST_CAL_LINK:
    assert property (adc_cal_o |-> cal_busy_o)
    else $error("calibration runs with bit clear");
  AST_ERR_STICKY:
    assert property ($fell(received_checksum_error_flag_o) |-> $past(error_clear_i))
    else $error("error flag cleared without write");
  AST_ALERT:
    assert property (checksum_alert_o
      == (checksum_error_interrupt_enable_i && received_checksum_error_flag_o))
    else $error("checksum alert wrong");
  AST_RESULT_TIME:
    assert property ($rose(result_valid_o) |-> $past(adc_done_i, 2))
    else $error("result valid off time");
  AST_THRESH:
    assert property (result_valid_o |-> alert_high_o == (result_o[15:4] > high_threshold_i))
    else $error("high alert wrong");
  AST_SDO_IDLE:
    assert property (cs_b_i [*4] |-> !sdo_oe_o)
    else $error("serial output driven while idle");
endmodule

// [sim/acgc_host_model.sv]
// Host serial controller model
`timescale 1ns/100ps
`include "acgc_defs.vh"
module acgc_host_model
(
  // Clock
  input wire clk_i,
  // Serial pins
  input wire sdo_i,
  output reg cs_b_o,
  output reg sclk_o,
  output reg sdi_o
);
  reg [47:0] rx;
  initial
  begin
    cs_b_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    rx = 48'h0;
  end
  function [7:0] crc8(input [7:0] b);
    integer i;
    begin
      crc8 = b;
      for (i = 0; i < 8; i = i + 1)
        crc8 = {crc8[6:0], 1'b0} ^ (crc8[7] ? 8'h07 : 8'h00);
    end
  endfunction
  // Mode 0 frame, sclk stands low outside it
  task frame(input [47:0] tx, input integer nb);
    integer i;
    begin
      @(posedge clk_i) cs_b_o <= 1'b0;
      for (i = nb - 1; i >= 0; i = i - 1)
      begin
        sdi_o <= tx[i];
        repeat (8) @(posedge clk_i);
        sclk_o <= 1'b1;
        rx <= {rx[46:0], sdo_i};
        repeat (8) @(posedge clk_i);
        sclk_o <= 1'b0;
      end
      repeat (8) @(posedge clk_i);
      cs_b_o <= 1'b1;
      sdi_o <= ~sdi_o;
      repeat (24) @(posedge clk_i);
    end
  endtask
  task write_reg(input [7:0] a, input [7:0] d, input crc_on, input bad);
    begin
      if (crc_on)
        frame({`ACGC_OP_WRITE, crc8(`ACGC_OP_WRITE), a, crc8(a), d,
          crc8(d) ^ {7'h00, bad}}, 48);
      else
        frame({24'h000000, `ACGC_OP_WRITE, a, d}, 24);
    end
  endtask
endmodule

// [sim/test_acgc_top.sv]
// Testbench for the converter control top
`timescale 1ns/100ps
`include "acgc_defs.vh"
module test_acgc_top;
  reg clk_i = 1'b0, rst_b_i = 1'b0, crc_enable_i = 1'b0, auto_mode_i = 1'b0;
  reg [2:0] averaging_ratio_i = 3'h0, conv_channel_i = 3'h0;
  reg [7:0] sequence_channel_mask_i = 8'h00, ext_lvl = 8'h00, force_lo = 8'h00;
  reg checksum_error_interrupt_enable_i = 1'b0, stop_on_error_i = 1'b0;
  reg [1:0] output_append_select_i = 2'h0;
  reg [11:0] high_threshold_i = 12'hfff, low_threshold_i = 12'h000;
  reg cal_trigger_i = 1'b0, error_clear_i = 1'b0, conv_request_i = 1'b0;
  reg adc_done_i = 1'b0, adc_cal_done_i = 1'b0;
  reg [11:0] adc_code_i = 12'h000, code_base = 12'h000, nst = 12'h000;
  reg [3:0] dly = 4'h0;
  wire cs_b_i, sclk_i, sdi_i, sdo_o, sdo_oe_o, adc_start_o, adc_cal_o, cal_busy_o;
  wire received_checksum_error_flag_o, checksum_alert_o, alert_high_o, alert_low_o;
  wire result_valid_o;
  wire [2:0] adc_channel_o, result_channel_o;
  wire [15:0] result_o;
  wire [7:0] input_level_register_o, pin_o, pin_oe_o, pin_i;
  integer n_mismatch = 0, check_count = 0, i, n_start;
  // Driven pins win, else pull level; forced lows model a shorted pin
  assign pin_i = ((pin_oe_o & pin_o) | (~pin_oe_o & ext_lvl)) & ~force_lo;
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  acgc_host_model host (.clk_i(clk_i), .sdo_i(sdo_o), .cs_b_o(cs_b_i),
    .sclk_o(sclk_i), .sdi_o(sdi_i));
  acgc_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .sclk_i(sclk_i),
    .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .crc_enable_i(crc_enable_i),
    .averaging_ratio_i(averaging_ratio_i), .auto_mode_i(auto_mode_i),
    .sequence_channel_mask_i(sequence_channel_mask_i),
    .checksum_error_interrupt_enable_i(checksum_error_interrupt_enable_i),
    .output_append_select_i(output_append_select_i), .stop_on_error_i(stop_on_error_i),
    .high_threshold_i(high_threshold_i), .low_threshold_i(low_threshold_i),
    .cal_trigger_i(cal_trigger_i), .error_clear_i(error_clear_i),
    .conv_request_i(conv_request_i), .conv_channel_i(conv_channel_i),
    .adc_start_o(adc_start_o), .adc_channel_o(adc_channel_o), .adc_done_i(adc_done_i),
    .adc_code_i(adc_code_i), .adc_cal_o(adc_cal_o), .adc_cal_done_i(adc_cal_done_i),
    .cal_busy_o(cal_busy_o), .received_checksum_error_flag_o(received_checksum_error_flag_o),
    .checksum_alert_o(checksum_alert_o), .alert_high_o(alert_high_o),
    .alert_low_o(alert_low_o), .result_o(result_o), .result_channel_o(result_channel_o),
    .result_valid_o(result_valid_o), .input_level_register_o(input_level_register_o),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
  // Converter core: answers each start after four cycles, codes step by 2
  always @(posedge clk_i)
  begin
    adc_done_i <= 1'b0;
    if (conv_request_i)
      nst <= 12'h000;
    if (adc_start_o)
    begin
      nst <= nst + 12'h001;
      dly <= 4'h3;
    end
    else if (dly != 4'h0)
    begin
      dly <= dly - 4'h1;
      if (dly == 4'h1)
      begin
        adc_done_i <= 1'b1;
        adc_code_i <= code_base + (nst << 1) - 12'h002;
      end
    end
  end
  task close_out;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [23:0] seen, input [23:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task settle;
    begin
      repeat (2) @(posedge clk_i);
      #1;
    end
  endtask
  task pulse_cal(input integer which);
    begin
      @(posedge clk_i);
      if (which == 0) cal_trigger_i <= 1'b1; else adc_cal_done_i <= 1'b1;
      @(posedge clk_i);
      cal_trigger_i <= 1'b0;
      adc_cal_done_i <= 1'b0;
      #1;
    end
  endtask
  task wait_valid;
    begin
      for (i = 0; i < 300; i = i + 1)
      begin
        @(posedge clk_i);
        #1;
        if (result_valid_o === 1'b1) i = 400;
      end
      chk("result_valid", (i == 401), 1);
      if (i != 401) close_out;
    end
  endtask
  task conv(input [2:0] ch);
    begin
      @(posedge clk_i) conv_request_i <= 1'b1;
      conv_channel_i <= ch;
      @(posedge clk_i) conv_request_i <= 1'b0;
      wait_valid;
    end
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    settle;
    chk("pin_oe", pin_oe_o, 8'h00);
    chk("input_level", input_level_register_o, 8'h00);
    $display("test reset done");
    @(posedge clk_i);
    ext_lvl <= 8'hf5;
    force_lo <= 8'h02;
    host.write_reg(`ACGC_ADDR_PIN_FUNCTION, 8'h0f, 1'b0, 1'b0);
    host.write_reg(`ACGC_ADDR_DIRECTION, 8'h03, 1'b0, 1'b0);
    host.write_reg(`ACGC_ADDR_OUTPUT_DRIVE, 8'h02, 1'b0, 1'b0);
    host.write_reg(`ACGC_ADDR_OUTPUT_LEVEL, 8'h03, 1'b0, 1'b0);
    settle;
    chk("pin_oe", pin_oe_o, 8'h02);
    chk("pin_o", pin_o & pin_oe_o, 8'h02);
    chk("input_level", input_level_register_o, 8'h05);
    host.write_reg(`ACGC_ADDR_OUTPUT_LEVEL, 8'h00, 1'b0, 1'b0);
    settle;
    chk("pin_oe", pin_oe_o, 8'h03);
    chk("pin_o", pin_o, 8'h00);
    $display("test pins done");
    pulse_cal(0);
    chk("cal_busy", cal_busy_o, 1);
    settle;
    chk("adc_cal", adc_cal_o, 1);
    pulse_cal(1);
    // poll until the bit reads cleared
    for (i = 0; i < 20 && cal_busy_o !== 1'b0; i = i + 1)
    begin
      @(posedge clk_i);
      #1;
    end
    chk("cal_busy", cal_busy_o, 0);
    $display("test calibration done");
    @(posedge clk_i);
    code_base <= 12'h800;
    low_threshold_i <= 12'h801;
    conv(3'h5);
    chk("result", result_o, 16'h8000);
    chk("result_channel", result_channel_o, 3'h5);
    chk("alert_low", alert_low_o, 1);
    host.write_reg(`ACGC_ADDR_OUTPUT_LEVEL, 8'h00, 1'b0, 1'b0);
    chk("sdo_plain", host.rx[23:0], 24'h800000);
    averaging_ratio_i <= 3'h2;
    code_base <= 12'h100;
    high_threshold_i <= 12'h102;
    low_threshold_i <= 12'h000;
    output_append_select_i <= `ACGC_OUTPUT_APPEND_SELECT;
    conv(3'h6);
    chk("result", result_o, 16'h1030);
    chk("starts", nst, 12'h004);
    chk("alert_high", alert_high_o, 1);
    chk("alert_low", alert_low_o, 0);
    host.write_reg(`ACGC_ADDR_OUTPUT_LEVEL, 8'h00, 1'b0, 1'b0);
    chk("sdo_word", host.rx[23:0], 24'h103020);
    $display("test averaging done");
    crc_enable_i <= 1'b1;
    checksum_error_interrupt_enable_i <= 1'b1;
    host.write_reg(`ACGC_ADDR_OUTPUT_LEVEL, 8'h01, 1'b1, 1'b0);
    settle;
    chk("pin_oe", pin_oe_o, 8'h02);
    chk("sdo_crc_hi", host.rx[47:24], {8'h10, host.crc8(8'h10), 8'h30});
    chk("sdo_crc_lo", host.rx[23:0], {host.crc8(8'h30), 8'h20, host.crc8(8'h20)});
    host.write_reg(`ACGC_ADDR_OUTPUT_LEVEL, 8'h00, 1'b1, 1'b1);
    settle;
    chk("err_flag", received_checksum_error_flag_o, 1);
    chk("alert", checksum_alert_o, 1);
    chk("pin_oe", pin_oe_o, 8'h02);
    host.write_reg(`ACGC_ADDR_OUTPUT_LEVEL, 8'h00, 1'b1, 1'b0);
    settle;
    chk("pin_oe", pin_oe_o, 8'h02);
    chk("sdo_status", host.rx[15:0], {8'ha0, host.crc8(8'ha0)});
    @(posedge clk_i) error_clear_i <= 1'b1;
    @(posedge clk_i) error_clear_i <= 1'b0;
    settle;
    chk("err_flag", received_checksum_error_flag_o, 0);
    host.write_reg(`ACGC_ADDR_OUTPUT_LEVEL, 8'h00, 1'b1, 1'b0);
    settle;
    chk("pin_oe", pin_oe_o, 8'h03);
    $display("test checksum done");
    @(posedge clk_i);
    sequence_channel_mask_i <= 8'h30;
    stop_on_error_i <= 1'b1;
    auto_mode_i <= 1'b1;
    wait_valid;
    chk("auto_channel", result_channel_o, 3'h4);
    wait_valid;
    chk("auto_channel", result_channel_o, 3'h5);
    host.write_reg(`ACGC_ADDR_OUTPUT_LEVEL, 8'h00, 1'b1, 1'b1);
    n_start = 0;
    for (i = 0; i < 60; i = i + 1)
    begin
      @(posedge clk_i);
      #1;
      if (adc_start_o !== 1'b0) n_start = n_start + 1;
    end
    chk("halted_starts", n_start, 0);
    @(posedge clk_i) error_clear_i <= 1'b1;
    @(posedge clk_i) error_clear_i <= 1'b0;
    auto_mode_i <= 1'b0;
    $display("test autonomous done");
    close_out;
  end
endmodule
bind acgc_top acgc_top_properties u_prop (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .cs_b_i(cs_b_i), .sdo_oe_o(sdo_oe_o), .cal_trigger_i(cal_trigger_i),
  .adc_cal_done_i(adc_cal_done_i), .adc_cal_o(adc_cal_o), .cal_busy_o(cal_busy_o),
  .error_clear_i(error_clear_i),
  .received_checksum_error_flag_o(received_checksum_error_flag_o),
  .checksum_alert_o(checksum_alert_o),
  .checksum_error_interrupt_enable_i(checksum_error_interrupt_enable_i),
  .adc_done_i(adc_done_i), .result_valid_o(result_valid_o), .result_o(result_o),
  .alert_high_o(alert_high_o), .high_threshold_i(high_threshold_i), .pin_oe_o(pin_oe_o));
